// file: core/slwd_chip_check.sv
// slwd_chip_check.sv: code violation and bit change detectors on the chip
// stream.
// assumes chip_stb marks one valid chip per pulse, synchronous to clk_sys.
`timescale 1ns/1ps
module slwd_chip_check (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic clear,      // drops chip history
  input  wire logic chip_stb,   // one chip arrives
  input  wire logic chip_val,   // value of that chip
  output logic      code_viol,  // three equal chips in a row
  output logic      bit_change  // two equal chips in a row
);

  logic [1:0] hist_ff;   // previous two chips, newest in bit 0
  logic [1:0] have_ff;   // history fill, one bit per held chip

  // chip history, restarted at each search
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hist_ff <= 2'h0;
      have_ff <= 2'h0;
    end else if (clear) begin
      hist_ff <= 2'h0;
      have_ff <= 2'h0;
    end else if (chip_stb) begin
      hist_ff <= {hist_ff[0], chip_val};
      have_ff <= {have_ff[0], 1'b1};
    end
  end

  // equal pairs and triples on the arriving chip
  always_comb begin
    bit_change = chip_stb & have_ff[0] & (chip_val == hist_ff[0]);
    code_viol  = bit_change & have_ff[1]
               & (hist_ff[0] == hist_ff[1]);
  end

  // violation needs three equal chips
  cv_three_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    code_viol |-> have_ff == 2'h3 && chip_val == hist_ff[0]
    && chip_val == hist_ff[1])
    else $error("code violation without equal chips");

endmodule

// file: core/slwd_params.svh
// slwd_params.svh: register offsets, field positions, reset values and
// timing counts of the symbol lock and wake detect block.
// assumes inclusion by bare name from every design file that needs it.
`ifndef SLWD_PARAMS_SVH
`define SLWD_PARAMS_SVH

// register offsets, configuration set a
`define SLWD_ADR_CRIT_A   8'h25
`define SLWD_ADR_PATL_A   8'h26
`define SLWD_ADR_PATH_A   8'h27
`define SLWD_ADR_CCNT_A   8'h28
`define SLWD_ADR_PROP_A   8'h73
`define SLWD_ADR_INTEG_A  8'h74
`define SLWD_ADR_SYNC_PREAMBLE_A  8'h75
`define SLWD_ADR_VWIN_A   8'h77
// register offsets, configuration set b
`define SLWD_ADR_CRIT_B   8'h46
`define SLWD_ADR_PATL_B   8'h47
`define SLWD_ADR_PATH_B   8'h48
`define SLWD_ADR_CCNT_B   8'h49
`define SLWD_ADR_PROP_B   8'h93
`define SLWD_ADR_INTEG_B  8'h94
`define SLWD_ADR_SYNC_PREAMBLE_B  8'h95
`define SLWD_ADR_VWIN_B   8'h97

// reset value of every configuration register
`define SLWD_REG_RST      8'h00
// field positions
`define SLWD_CRIT_MSB     1
`define SLWD_CCNT_MSB     6
`define SLWD_SYNC_PREAMBLE_LENGTH_FIELD_MSB   1

// timing in sixteenths of a bit period
`define SLWD_TICKS_PER_BIT 16
// run-in sync budget: four symbols
`define SLWD_SYNC_PREAMBLE_BITS    4
// sync search timeout 7.625 bits, held as eighths of a bit
`define SLWD_VDR_EIGHTHS   61
// pattern length in chips
`define SLWD_PAT_CHIPS     16

`endif

// file: core/slwd_pattern_match.sv
// slwd_pattern_match.sv: 16-chip pattern correlator for wake-up search.
// assumes chip_stb marks one valid chip per pulse; newest chip in bit 0.
`timescale 1ns/1ps
`include "slwd_params.svh"
module slwd_pattern_match #(
  parameter int CHIPS = `SLWD_PAT_CHIPS
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             clear,     // restarts filling
  input  wire logic             chip_stb,  // one chip arrives
  input  wire logic             chip_val,  // value of that chip
  input  wire logic [CHIPS-1:0] pattern,   // chip 0 in the lsb
  output logic                  match      // window equals pattern
);

  logic [CHIPS-2:0] shift_ff;  // previous chips
  logic [4:0]       fill_ff;   // chips held so far, saturating
  logic [CHIPS-1:0] window;    // previous chips plus the arriving one

  // shift register and fill count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shift_ff <= '0;
      fill_ff  <= 5'h00;
    end else if (clear) begin
      shift_ff <= '0;
      fill_ff  <= 5'h00;
    end else if (chip_stb) begin
      shift_ff <= {shift_ff[CHIPS-3:0], chip_val};
      if (fill_ff != 5'(CHIPS - 1)) begin
        fill_ff <= fill_ff + 5'h01;
      end
    end
  end

  // compare only once the register is full
  always_comb begin
    window = {shift_ff, chip_val};
    match  = chip_stb & (fill_ff == 5'(CHIPS - 1))
           & (window == pattern);
  end

endmodule

// file: core/slwd_pkg.sv
// slwd_pkg.sv: types shared by the symbol lock and wake detect block.
// assumes nothing beyond a sv-2012 compiler.
package slwd_pkg;

  // wake criterion field encodings
  typedef enum logic [1:0] {
    SLWD_CRIT_PATTERN = 2'b00,
    SLWD_CRIT_RANDOM  = 2'b01,
    SLWD_CRIT_EQUAL   = 2'b10,
    SLWD_CRIT_RATE    = 2'b11
  } slwd_crit_t;

  // wake search states
  typedef enum logic [1:0] {
    SLWD_ST_IDLE    = 2'b00,
    SLWD_ST_WAIT    = 2'b01,
    SLWD_ST_OBSERVE = 2'b10
  } slwd_state_t;

endpackage

// file: core/slwd_top.sv
// slwd_top.sv: symbol lock supervision and wake-up criterion search.
// assumes the recovery loop supplies ref_edge, sync_found and a 1/16 bit
// tick; the framer supplies the gap level and end-of-message pulse.
//
// Behaviour
// - drop lock when edges absent past window
// - gap freezes loop and violation timer
// - violation window counts sixteenth-bit steps
// - wake search only in self-polling, active set
// - search needs sync within four run-in symbols, within 7.625 bits in rate mode
// - sync loss aborts observation at once
// - count chips, compare with programmed count
// - three equal chips flag code violation
// - two equal chips flag bit change
// - compare last 16 chips with pattern
// - criterion field selects one of four modes
// - pattern match inside window wakes
// - equal bits wake, differing bit aborts
// - no violation in window wakes
// - sync before timeout wakes, count ignored
// - chip count zero: immediate or never
// - end of message drops lock
`timescale 1ns/1ps
`include "slwd_params.svh"
module slwd_top #(
  parameter int SYNC_PREAMBLE_TICKS = `SLWD_SYNC_PREAMBLE_BITS * `SLWD_TICKS_PER_BIT,
  parameter int VDR_TICKS   = `SLWD_VDR_EIGHTHS * `SLWD_TICKS_PER_BIT / 8
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       reg_wr,        // register write strobe
  input  wire logic [7:0] reg_addr,      // register offset
  input  wire logic [7:0] reg_wdata,     // register write data
  input  wire logic       cfg_sel_b,     // high: set b active
  input  wire logic       self_poll,     // self-polling mode active
  input  wire logic       search_start,  // run-in begins, start search
  input  wire logic       tick16,        // one sixteenth of a bit
  input  wire logic       ref_edge,      // reference edge seen
  input  wire logic       sync_found,    // loop reached symbol sync
  input  wire logic       tsi_gap,       // telegram-start gap level
  input  wire logic       end_of_message,// framer end of message
  input  wire logic       chip_stb,      // one chip arrives
  input  wire logic       chip_val,      // value of that chip
  output logic            symbol_lock,   // loop locked
  output logic            loop_freeze,   // hold loop state
  output logic            loop_resync,   // restart loop acquisition
  output logic [7:0]      prop_cfg,      // active proportional setting
  output logic [7:0]      integ_cfg,     // active integral setting
  output logic [1:0]      sync_preamble_len,     // active run-in length
  output logic            search_busy,   // wake search running
  output logic            wake_found,    // criterion met, one cycle
  output logic            wake_abort     // search given up, one cycle
);

  // configuration storage, index 0 set a, index 1 set b
  logic [7:0] crit_ff  [2];
  logic [7:0] patl_ff  [2];
  logic [7:0] path_ff  [2];
  logic [7:0] ccnt_ff  [2];
  logic [7:0] prop_ff  [2];
  logic [7:0] integ_ff [2];
  logic [7:0] sync_preamble_ff [2];
  logic [7:0] vwin_ff  [2];

  // register writes, one process per configuration set
  for (genvar s = 0; s < 2; s++) begin : g_set
    localparam logic [7:0] A_CRIT  = s ? `SLWD_ADR_CRIT_B  : `SLWD_ADR_CRIT_A;
    localparam logic [7:0] A_PATL  = s ? `SLWD_ADR_PATL_B  : `SLWD_ADR_PATL_A;
    localparam logic [7:0] A_PATH  = s ? `SLWD_ADR_PATH_B  : `SLWD_ADR_PATH_A;
    localparam logic [7:0] A_CCNT  = s ? `SLWD_ADR_CCNT_B  : `SLWD_ADR_CCNT_A;
    localparam logic [7:0] A_PROP  = s ? `SLWD_ADR_PROP_B  : `SLWD_ADR_PROP_A;
    localparam logic [7:0] A_INTEG = s ? `SLWD_ADR_INTEG_B : `SLWD_ADR_INTEG_A;
    localparam logic [7:0] A_SYNC_PREAMBLE = s ? `SLWD_ADR_SYNC_PREAMBLE_B : `SLWD_ADR_SYNC_PREAMBLE_A;
    localparam logic [7:0] A_VWIN  = s ? `SLWD_ADR_VWIN_B  : `SLWD_ADR_VWIN_A;
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        crit_ff[s]  <= `SLWD_REG_RST;
        patl_ff[s]  <= `SLWD_REG_RST;
        path_ff[s]  <= `SLWD_REG_RST;
        ccnt_ff[s]  <= `SLWD_REG_RST;
        prop_ff[s]  <= `SLWD_REG_RST;
        integ_ff[s] <= `SLWD_REG_RST;
        sync_preamble_ff[s] <= `SLWD_REG_RST;
        vwin_ff[s]  <= `SLWD_REG_RST;
      end else if (reg_wr) begin
        // unmapped offsets are ignored
        if (reg_addr == A_CRIT)  crit_ff[s]  <= reg_wdata;
        if (reg_addr == A_PATL)  patl_ff[s]  <= reg_wdata;
        if (reg_addr == A_PATH)  path_ff[s]  <= reg_wdata;
        if (reg_addr == A_CCNT)  ccnt_ff[s]  <= reg_wdata;
        if (reg_addr == A_PROP)  prop_ff[s]  <= reg_wdata;
        if (reg_addr == A_INTEG) integ_ff[s] <= reg_wdata;
        if (reg_addr == A_SYNC_PREAMBLE) sync_preamble_ff[s] <= reg_wdata;
        if (reg_addr == A_VWIN)  vwin_ff[s]  <= reg_wdata;
      end
    end
  end

  // active-set view of the settings
  logic                 act;        // active set index
  slwd_pkg::slwd_crit_t crit;       // active criterion
  logic [6:0]           chip_lim;   // active wake chip count
  logic [15:0]          pattern;    // active 16-chip pattern
  logic [7:0]           vwin;       // active violation window

  // select the active configuration set
  always_comb begin
    act      = cfg_sel_b;
    crit     = slwd_pkg::slwd_crit_t'(crit_ff[act][`SLWD_CRIT_MSB:0]);
    chip_lim = ccnt_ff[act][`SLWD_CCNT_MSB:0];
    pattern  = {path_ff[act], patl_ff[act]};
    vwin     = vwin_ff[act];
  end

  // loop settings handed to the recovery loop, registered
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prop_cfg  <= `SLWD_REG_RST;
      integ_cfg <= `SLWD_REG_RST;
      sync_preamble_len <= 2'h0;
    end else begin
      prop_cfg  <= prop_ff[act];
      integ_cfg <= integ_ff[act];
      sync_preamble_len <= sync_preamble_ff[act][`SLWD_SYNC_PREAMBLE_LENGTH_FIELD_MSB:0];
    end
  end

  // lock supervision
  logic       lock_ff;   // symbol lock state
  logic [8:0] vcnt_ff;   // sixteenths since last reference edge
  logic       drop_now;  // window exceeded

  // the gap freezes both loop and timer
  assign loop_freeze = tsi_gap;
  assign drop_now    = lock_ff & !tsi_gap & (vcnt_ff > {1'b0, vwin});
  assign symbol_lock = lock_ff;

  // edge-free time, in sixteenth-bit steps
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vcnt_ff <= 9'h000;
    end else if (!lock_ff || ref_edge || end_of_message) begin
      vcnt_ff <= 9'h000;
    end else if (tsi_gap) begin
      vcnt_ff <= vcnt_ff;
    end else if (tick16 && vcnt_ff != 9'h1ff) begin
      vcnt_ff <= vcnt_ff + 9'h001;
    end
  end

  // lock state: set by the loop, dropped by window or message end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lock_ff <= 1'b0;
    end else if (end_of_message) begin
      lock_ff <= 1'b0;
    end else if (drop_now) begin
      lock_ff <= 1'b0;
    end else if (sync_found) begin
      lock_ff <= 1'b1;
    end
  end

  // resync request follows a message end or a window drop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loop_resync <= 1'b0;
    end else begin
      loop_resync <= end_of_message | drop_now;
    end
  end

  // wake search
  slwd_pkg::slwd_state_t state_ff;  // search state
  logic [6:0]            tcnt_ff;   // sixteenths waited for sync
  logic [6:0]            ccnt_ob;   // chips seen in the window
  logic                  code_viol; // violation on arriving chip
  logic                  bit_change;// equal pair on arriving chip
  logic                  pat_hit;   // pattern match on arriving chip
  logic                  win_done;  // window elapsed
  logic [6:0]            sync_lim;  // sync budget for the mode
  logic                  found_now; // criterion met this cycle
  logic                  abort_now; // search ends without wake

  assign search_busy = (state_ff != slwd_pkg::SLWD_ST_IDLE);
  assign win_done    = (ccnt_ob >= chip_lim);
  assign sync_lim    = (crit == slwd_pkg::SLWD_CRIT_RATE)
                     ? 7'(VDR_TICKS) : 7'(SYNC_PREAMBLE_TICKS);

  // chip checks, history dropped while idle
  slwd_chip_check u_check (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .clear      (!search_busy),
    .chip_stb   (chip_stb),
    .chip_val   (chip_val),
    .code_viol  (code_viol),
    .bit_change (bit_change)
  );

  // pattern correlator
  slwd_pattern_match #(
    .CHIPS (`SLWD_PAT_CHIPS)
  ) u_pat (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .clear    (!search_busy),
    .chip_stb (chip_stb),
    .chip_val (chip_val),
    .pattern  (pattern),
    .match    (pat_hit)
  );

  // outcome of the current cycle
  always_comb begin
    found_now = 1'b0;
    abort_now = 1'b0;
    case (state_ff)
      slwd_pkg::SLWD_ST_WAIT: begin
        if (!self_poll) begin
          abort_now = 1'b1;
        end else if (lock_ff) begin
          found_now = (crit == slwd_pkg::SLWD_CRIT_RATE);
        end else if (tick16 && (tcnt_ff + 7'h01 >= sync_lim)) begin
          abort_now = 1'b1;
        end
      end
      slwd_pkg::SLWD_ST_OBSERVE: begin
        if (!self_poll || !lock_ff) begin
          abort_now = 1'b1;
        end else begin
          case (crit)
            slwd_pkg::SLWD_CRIT_PATTERN: begin
              // zero count never wakes: window already over
              if (win_done) abort_now = 1'b1;
              else if (pat_hit) found_now = 1'b1;
            end
            slwd_pkg::SLWD_CRIT_RANDOM: begin
              if (win_done) found_now = 1'b1;
              else if (code_viol) abort_now = 1'b1;
            end
            slwd_pkg::SLWD_CRIT_EQUAL: begin
              if (win_done) found_now = 1'b1;
              else if (bit_change) abort_now = 1'b1;
            end
            default: begin
              // rate mode is settled while waiting for sync
              abort_now = 1'b1;
            end
          endcase
        end
      end
      default: begin
        found_now = 1'b0;
        abort_now = 1'b0;
      end
    endcase
  end

  // search state machine
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= slwd_pkg::SLWD_ST_IDLE;
    end else begin
      case (state_ff)
        slwd_pkg::SLWD_ST_IDLE: begin
          if (search_start && self_poll) begin
            state_ff <= slwd_pkg::SLWD_ST_WAIT;
          end
        end
        slwd_pkg::SLWD_ST_WAIT: begin
          if (found_now || abort_now) begin
            state_ff <= slwd_pkg::SLWD_ST_IDLE;
          end else if (lock_ff) begin
            state_ff <= slwd_pkg::SLWD_ST_OBSERVE;
          end
        end
        slwd_pkg::SLWD_ST_OBSERVE: begin
          if (found_now || abort_now) begin
            state_ff <= slwd_pkg::SLWD_ST_IDLE;
          end
        end
        default: begin
          state_ff <= slwd_pkg::SLWD_ST_IDLE;
        end
      endcase
    end
  end

  // sync wait counter, in sixteenth-bit steps
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tcnt_ff <= 7'h00;
    end else if (state_ff != slwd_pkg::SLWD_ST_WAIT) begin
      tcnt_ff <= 7'h00;
    end else if (tick16) begin
      tcnt_ff <= tcnt_ff + 7'h01;
    end
  end

  // window chip counter, runs while observing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ccnt_ob <= 7'h00;
    end else if (state_ff != slwd_pkg::SLWD_ST_OBSERVE) begin
      ccnt_ob <= 7'h00;
    end else if (chip_stb && !win_done) begin
      ccnt_ob <= ccnt_ob + 7'h01;
    end
  end

  // result pulses, one cycle each
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wake_found <= 1'b0;
      wake_abort <= 1'b0;
    end else begin
      wake_found <= found_now;
      wake_abort <= abort_now;
    end
  end

  // named steps of an observation ending on sync loss
  sequence s_obs_loss;
    state_ff == slwd_pkg::SLWD_ST_OBSERVE && !lock_ff;
  endsequence
  sequence s_abort_seen;
    ##1 wake_abort && state_ff == slwd_pkg::SLWD_ST_IDLE;
  endsequence

  lock_window_drop_a: assert property (@(posedge clk_sys)
    disable iff (!resetn) drop_now |=> !lock_ff)
    else $error("lock kept past violation window");
  gap_timer_freeze_a: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    tsi_gap && lock_ff && !ref_edge && !end_of_message
    |=> $stable(vcnt_ff) && lock_ff)
    else $error("timer or lock moved during gap");
  eom_lock_drop_a: assert property (@(posedge clk_sys)
    disable iff (!resetn) end_of_message |=> !lock_ff && loop_resync)
    else $error("lock kept after end of message");
  sync_preamble_sync_abort_a: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    state_ff == slwd_pkg::SLWD_ST_WAIT && self_poll && !lock_ff
    && tick16 && tcnt_ff == 7'(SYNC_PREAMBLE_TICKS - 1)
    && crit != slwd_pkg::SLWD_CRIT_RATE |=> wake_abort)
    else $error("search kept without sync in run-in");
  sync_loss_abort_a: assert property (@(posedge clk_sys)
    disable iff (!resetn) s_obs_loss |-> s_abort_seen)
    else $error("observation kept after sync loss");
  found_one_cycle_a: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    wake_found |-> !search_busy ##1 !wake_found)
    else $error("wake pulse longer than one cycle");
  chip_count_step_a: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    state_ff == slwd_pkg::SLWD_ST_OBSERVE && chip_stb && !win_done
    && !abort_now && !found_now |=> ccnt_ob == $past(ccnt_ob) + 7'h01)
    else $error("window chip count did not advance");
  random_cv_abort_a: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    state_ff == slwd_pkg::SLWD_ST_OBSERVE && lock_ff && self_poll
    && crit == slwd_pkg::SLWD_CRIT_RANDOM && !win_done && code_viol
    |=> wake_abort && !wake_found)
    else $error("violation did not stop random search");
  pattern_wake_a: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    state_ff == slwd_pkg::SLWD_ST_OBSERVE && lock_ff && self_poll
    && crit == slwd_pkg::SLWD_CRIT_PATTERN && !win_done && pat_hit
    |=> wake_found)
    else $error("pattern match did not wake");

endmodule

// file: tb/slwd_tx_model.sv
// slwd_tx_model.sv: behavioural transmitter that feeds the chip stream.
// assumes go, word and count change by nba at the falling clock edge.
`timescale 1ns/1ps
module slwd_tx_model (
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic [15:0] word,
  input  wire logic [4:0]  count,
  output logic             chip_stb,
  output logic             chip_val,
  output logic             busy
);
  logic [15:0] sh;    // chips still to send, next one in the msb
  logic [4:0]  left;  // chips left in the burst
  logic [1:0]  gap;   // clocks between two chips
  initial begin
    {chip_stb, chip_val, busy, sh, left, gap} = '0;
  end
  // one chip every fourth clock; outside a strobe the line flips
  always @(negedge clk_sys) begin
    chip_stb <= busy && (gap == 2'd3);
    if (go && !busy) begin
      sh <= word << (5'd16 - count);
      left <= count;
      gap <= 2'd0;
      busy <= (count != 5'd0);
    end else if (busy) begin
      gap <= gap + 2'd1;
      if (gap == 2'd3) begin
        chip_val <= sh[15];
        sh <= sh << 1;
        left <= left - 5'd1;
        busy <= (left != 5'd1);
      end else if (gap == 2'd0) chip_val <= ~chip_val;  // stale value hidden
    end
  end
endmodule

// file: tb/symbol_lock_and_wake_detect_tb.sv
// symbol_lock_and_wake_detect_tb.sv: register, lock and wake search tests.
// assumes slwd_top and the transmitter model compiled before it.
`timescale 1ns/1ps
module symbol_lock_and_wake_detect_tb;
  logic        clk_sys, resetn, reg_wr, cfg_sel_b, self_poll, tick16;
  logic        search_start, ref_edge, sync_found, tsi_gap, end_of_message;
  logic        chip_stb, chip_val, go, busy, symbol_lock, loop_freeze;
  logic        loop_resync, search_busy, wake_found, wake_abort;
  logic [7:0]  reg_addr, reg_wdata, prop_cfg, integ_cfg;
  logic [1:0]  sync_preamble_len;
  logic [15:0] word;
  logic [4:0]  count;
  logic [3:0]  pv;  // one-cycle control pulses
  int          err_count, comparisons;
  localparam logic [3:0] START = 4'h8, SYNC = 4'h4, END_OF_MESSAGE = 4'h2, EDGE = 4'h1;
  assign {search_start, sync_found, end_of_message, ref_edge} = pv;
  slwd_top u_slwd_top (.clk_sys, .resetn, .reg_wr, .reg_addr, .reg_wdata,
    .cfg_sel_b, .self_poll, .search_start, .tick16, .ref_edge, .sync_found,
    .tsi_gap, .end_of_message, .chip_stb, .chip_val, .symbol_lock,
    .loop_freeze, .loop_resync, .prop_cfg, .integ_cfg, .sync_preamble_len,
    .search_busy, .wake_found, .wake_abort);
  slwd_tx_model u_slwd_tx_model (.clk_sys, .go, .word, .count, .chip_stb,
    .chip_val, .busy);
  // 200 mhz system clock
  always #2.5 clk_sys = ~clk_sys;
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one register write, strobe held for one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic pls(input logic [3:0] m);
    @(negedge clk_sys);
    pv <= m;
    @(negedge clk_sys);
    pv <= 4'h0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      tick16 <= 1'b1;
      @(negedge clk_sys);
      tick16 <= 1'b0;
    end
  endtask
  // starts a chip burst once the transmitter is free
  task automatic burst(input logic [15:0] w, input logic [4:0] n);
    int i;
    for (i = 0; i < 99 && busy === 1'b1; i++) @(negedge clk_sys);
    if (i == 99) begin
      err_count++;
      $display("CHECK FAILED at %0t: transmitter stuck", $time);
      give_verdict();
    end
    @(negedge clk_sys);
    go <= 1'b1;
    word <= w;
    count <= n;
    @(negedge clk_sys);
    go <= 1'b0;
  endtask
  // waits for a verdict pulse, then checks it lasted one cycle
  task automatic outcome(input logic f, input logic a);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk_sys);
      if (wake_found === 1'b1 || wake_abort === 1'b1) break;
    end
    if (i == 400) begin
      err_count++;
      $display("CHECK FAILED at %0t: no search verdict", $time);
      give_verdict();
    end else begin
      chk(wake_found, f);
      chk(wake_abort, a);
      cyc(1);
      chk({wake_found, wake_abort, search_busy}, 8'h00);
    end
  endtask
  // one search with lock given at once, chips from the transmitter
  task automatic run(input logic [7:0] ca, input logic [7:0] crit,
                     input logic [7:0] cnt, input logic [15:0] w,
                     input logic [4:0] n, input logic f, input logic a);
    wr(ca, crit);
    wr(ca + 8'h03, cnt);
    pls(START);
    pls(SYNC);
    if (n != 5'd0) burst(w, n);
    outcome(f, a);
    pls(END_OF_MESSAGE);
  endtask
  initial begin
    {clk_sys, resetn, reg_wr, cfg_sel_b, tick16, tsi_gap, go} = '0;
    {reg_addr, reg_wdata, word, count, pv, err_count, comparisons} = '0;
    self_poll = 1'b1;
    cyc(8);
    resetn <= 1'b1;
    cyc(2);
    chk(prop_cfg | integ_cfg | {6'h00, sync_preamble_len}, 8'h00);
    wr(8'h73, 8'he6);
    wr(8'h74, 8'h65);
    wr(8'h75, 8'h01);
    wr(8'h93, 8'h5a);
    wr(8'h94, 8'ha5);
    wr(8'h95, 8'h02);
    wr(8'h76, 8'hff);
    chk(prop_cfg, 8'he6);
    chk(integ_cfg, 8'h65);
    chk(sync_preamble_len, 8'h01);
    cfg_sel_b <= 1'b1;
    cyc(2);
    chk(prop_cfg, 8'h5a);
    chk(integ_cfg, 8'ha5);
    chk({6'h00, sync_preamble_len}, 8'h02);
    cfg_sel_b <= 1'b0;
    $display("test config done");
    wr(8'h77, 8'h02);
    pls(SYNC);
    cyc(1);
    chk(symbol_lock, 8'h01);
    ticks(2);
    pls(EDGE);
    ticks(2);
    chk(symbol_lock, 8'h01);
    tsi_gap <= 1'b1;
    ticks(6);
    chk({loop_freeze, symbol_lock}, 8'h03);
    tsi_gap <= 1'b0;
    ticks(1);
    cyc(1);
    chk(loop_resync, 8'h01);
    cyc(2);
    chk(symbol_lock, 8'h00);
    pls(SYNC);
    pls(END_OF_MESSAGE);
    chk(loop_resync, 8'h01);
    cyc(1);
    chk(symbol_lock, 8'h00);
    wr(8'h77, 8'h14);
    $display("test lock done");
    run(8'h25, 8'h01, 8'h02, 16'h0002, 5'd2, 1'b1, 1'b0);
    run(8'h25, 8'h01, 8'h08, 16'h0007, 5'd3, 1'b0, 1'b1);
    run(8'h25, 8'h02, 8'h04, 16'h0004, 5'd3, 1'b0, 1'b1);
    run(8'h25, 8'h02, 8'h02, 16'h0002, 5'd2, 1'b1, 1'b0);
    wr(8'h26, 8'hc3);
    wr(8'h27, 8'ha5);
    run(8'h25, 8'h00, 8'h11, 16'ha5c3, 5'd16, 1'b1, 1'b0);
    run(8'h25, 8'h03, 8'h00, 16'h0000, 5'd0, 1'b1, 1'b0);
    run(8'h25, 8'h01, 8'h00, 16'h0000, 5'd0, 1'b1, 1'b0);
    run(8'h25, 8'h00, 8'h00, 16'h0000, 5'd0, 1'b0, 1'b1);
    cfg_sel_b <= 1'b1;
    run(8'h46, 8'h03, 8'h00, 16'h0000, 5'd0, 1'b1, 1'b0);
    cfg_sel_b <= 1'b0;
    $display("test criteria done");
    wr(8'h25, 8'h01);
    pls(START);
    ticks(63);
    chk(search_busy, 8'h01);
    ticks(1);
    chk(wake_found, 8'h00);
    chk(wake_abort, 8'h01);
    cyc(1);
    chk({wake_found, wake_abort, search_busy}, 8'h00);
    wr(8'h28, 8'h08);
    pls(START);
    pls(SYNC);
    cyc(2);
    pls(END_OF_MESSAGE);
    outcome(1'b0, 1'b1);
    self_poll <= 1'b0;
    pls(START);
    cyc(2);
    chk(search_busy, 8'h00);
    self_poll <= 1'b1;
    $display("test abort done");
    give_verdict();
  end
endmodule
